/* File: verilog/srx_receiver.sv */
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
// How it works
// - a low sample that fails edge qualification restarts the tick count.
// - a falling edge counts only after three high samples before it.
// - disagreeing samples at ticks 8-10 of a data or stop bit set noise, no restart.
// - in the start bit the samples at ticks 8-10 are not evaluated.
// - a stop bit whose samples vote zero sets the framing error flag, except in standby.
// - a break (all low, no stop bit) also sets the framing error flag.
// - framing error is set in the same cycle as receive full.
// - the stop bit is sampled at ticks 8, 9 and 10 and then finishes.
// - with 8 data bits sampling ends 154 ticks after the start edge.
// - with 9 data bits sampling ends 170 ticks after the start edge.
// - standby masks the receiver interrupt.
// - in standby data is still stored but receive full is not set.
// - a select bit picks idle line or address mark wakeup.
module srx_receiver (
  input wire logic core_clk, // module clock
  input wire logic rst_b, // async reset, low
  input wire logic rxd, // serial line in
  input wire logic [3:0] addr, // register address
  input wire logic [15:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [15:0] rdata, // read data, next cycle
  output logic irq // level interrupt
);
  srx_tick_if tk ();
  srx_pkg::srx_state_t state_r;
  logic [3:0] ctrl_r;
  logic [srx_pkg::ST_W-1:0] stat_r;
  logic [srx_pkg::ST_W-1:0] ien_r;
  logic [15:0] div_r;
  logic [8:0] data_r;
  logic [8:0] shift_r;
  logic [3:0] phase_r;
  logic [3:0] bitn_r;
  logic [2:0] hist_r;
  logic [2:0] samp_r;
  logic [3:0] idle_r;
  logic [15:0] rdata_r;
  logic done;
  logic full_set;
  logic fe_set;
  logic noise_set;
  logic idle_set;
  logic wake;
  logic maj;
  logic idle_hold;
  logic ctrl_wr;
  logic [3:0] idle_tk_r;
  logic [3:0] nbits;
  logic clr_wr;

  srx_tick_gen u_tick (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .tk(tk)
  );

  // ****************************************************************
  // helper functions
  // ****************************************************************
  // two of three vote
  function automatic logic vote(input logic [2:0] s);
    vote = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction
  // three samples disagree
  function automatic logic split(input logic [2:0] s);
    split = (s != 3'b000) && (s != 3'b111);
  endfunction

  // ****************************************************************
  // sampling state machine
  // ****************************************************************
  assign tk.div = div_r;
  assign nbits = ctrl_r[srx_pkg::CTRL_NINE] ? 4'h9 : 4'h8;
  assign maj = vote({samp_r[1:0], rxd});
  // hunt restarts the divider when a low appears without qualification
  assign tk.restart = (state_r == srx_pkg::SRX_HUNT) && tk.tick &&
                      !rxd && (hist_r != 3'b111);
  // end of stop bit sampling at tick 10 of the last bit time
  assign done = tk.tick && (state_r == srx_pkg::SRX_STOP) &&
                (phase_r == srx_pkg::TICK_S3);
  assign fe_set = done && !maj;
  assign full_set = done && !ctrl_r[srx_pkg::CTRL_STANDBY];
  assign noise_set = tk.tick && (phase_r == srx_pkg::TICK_S3) &&
                     (state_r == srx_pkg::SRX_DATA ||
                      state_r == srx_pkg::SRX_STOP) &&
                     split({samp_r[1:0], rxd});

  // high-sample history for edge qualification
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      hist_r <= 3'b111; // line idles high
    end else if (tk.tick) begin
      hist_r <= {hist_r[1:0], rxd};
    end
  end

  // tick samples 8 and 9 of each bit; the tick 10 sample is rxd itself
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      samp_r <= 3'b000;
    end else if (tk.tick && (phase_r == srx_pkg::TICK_S1 ||
                             phase_r == srx_pkg::TICK_S2)) begin
      samp_r <= {samp_r[1:0], rxd};
    end
  end

  // frame sequencing: start, data bits, stop
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= srx_pkg::SRX_HUNT;
      phase_r <= 4'h0;
      bitn_r <= 4'h0;
      shift_r <= 9'h000;
    end else if (!ctrl_r[srx_pkg::CTRL_RXEN]) begin
      state_r <= srx_pkg::SRX_HUNT;
      phase_r <= 4'h0;
    end else if (tk.tick) begin
      unique case (state_r)
        srx_pkg::SRX_HUNT: begin
          // three highs then a low make a start edge
          if (!rxd && hist_r == 3'b111) begin
            state_r <= srx_pkg::SRX_START;
            phase_r <= 4'h1;
            bitn_r <= 4'h0;
            shift_r <= 9'h000;
          end
        end
        srx_pkg::SRX_START: begin
          // start bit runs its 16 ticks, its samples are not voted
          phase_r <= phase_r + 4'h1;
          if (phase_r == srx_pkg::TICK_LAST) begin
            state_r <= srx_pkg::SRX_DATA;
          end
        end
        srx_pkg::SRX_DATA: begin
          phase_r <= phase_r + 4'h1;
          if (phase_r == srx_pkg::TICK_S3) begin
            // lsb first, shifted in from the top of the word
            if (ctrl_r[srx_pkg::CTRL_NINE]) begin
              shift_r <= {maj, shift_r[8:1]};
            end else begin
              shift_r <= {1'b0, maj, shift_r[7:1]};
            end
          end
          if (phase_r == srx_pkg::TICK_LAST) begin
            bitn_r <= bitn_r + 4'h1;
            if (bitn_r + 4'h1 == nbits) begin
              state_r <= srx_pkg::SRX_STOP;
            end
          end
        end
        srx_pkg::SRX_STOP: begin
          // finish at tick 10: 16*(n+1)+10 ticks from the edge
          phase_r <= phase_r + 4'h1;
          if (phase_r == srx_pkg::TICK_S3) begin
            state_r <= srx_pkg::SRX_HUNT;
            phase_r <= 4'h0;
          end
        end
      endcase
    end
  end

  // received word, loaded even in standby
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      data_r <= 9'h000;
    end else if (done) begin
      data_r <= shift_r;
    end
  end

  // ****************************************************************
  // idle detect and wakeup
  // ****************************************************************
  // any low, any frame or a control write starts the idle span afresh,
  // so standby entered on an already quiet line still waits a full span
  assign idle_hold = (state_r != srx_pkg::SRX_HUNT) || !rxd || ctrl_wr;

  // ticks within the current high bit time
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      idle_tk_r <= 4'h0;
    end else if (idle_hold) begin
      idle_tk_r <= 4'h0;
    end else if (tk.tick) begin
      idle_tk_r <= idle_tk_r + 4'h1;
    end
  end

  // whole high bit times, saturating
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      idle_r <= 4'h0;
    end else if (idle_hold) begin
      idle_r <= 4'h0;
    end else if (tk.tick && idle_tk_r == srx_pkg::TICK_LAST &&
                 idle_r != 4'hF) begin
      idle_r <= idle_r + 4'h1;
    end
  end

  // idle line once the last of the high bit times completes
  assign idle_set = tk.tick && !idle_hold &&
                    (idle_tk_r == srx_pkg::TICK_LAST) &&
                    (idle_r == srx_pkg::IDLE_BITS - 4'h1);
  // wake select: 0 idle line, 1 address mark in the msb
  assign wake = ctrl_r[srx_pkg::CTRL_STANDBY] &&
                (ctrl_r[srx_pkg::CTRL_WAKE] ?
                 (done && (ctrl_r[srx_pkg::CTRL_NINE] ? shift_r[8]
                                                      : shift_r[7]))
                 : idle_set);

  // ****************************************************************
  // register file
  // ****************************************************************
  assign clr_wr = wr && (addr == srx_pkg::ADDR_CLR);
  assign ctrl_wr = wr && (addr == srx_pkg::ADDR_CTRL);

  // control; standby cleared by hardware wakeup, a write wins
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= 4'h0;
    end else if (ctrl_wr) begin
      ctrl_r <= wdata[3:0];
    end else if (wake) begin
      ctrl_r[srx_pkg::CTRL_STANDBY] <= 1'b0;
    end
  end

  // clocks per oversample tick
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_r <= srx_pkg::DIV_RESET;
    end else if (wr && addr == srx_pkg::ADDR_DIV) begin
      div_r <= wdata;
    end
  end

  // interrupt enables, same layout as status
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ien_r <= '0;
    end else if (wr && addr == srx_pkg::ADDR_IEN) begin
      ien_r <= wdata[srx_pkg::ST_W-1:0];
    end
  end

  // sticky status, set beats clear
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stat_r <= '0;
    end else begin
      stat_r[srx_pkg::ST_FULL] <= full_set |
        (stat_r[srx_pkg::ST_FULL] & ~(clr_wr & wdata[srx_pkg::ST_FULL]));
      stat_r[srx_pkg::ST_FE] <= (fe_set & full_set) |
        (stat_r[srx_pkg::ST_FE] & ~(clr_wr & wdata[srx_pkg::ST_FE]));
      stat_r[srx_pkg::ST_NOISE] <= noise_set |
        (stat_r[srx_pkg::ST_NOISE] & ~(clr_wr & wdata[srx_pkg::ST_NOISE]));
      stat_r[srx_pkg::ST_IDLE] <= idle_set |
        (stat_r[srx_pkg::ST_IDLE] & ~(clr_wr & wdata[srx_pkg::ST_IDLE]));
    end
  end

  // read data one cycle after strobe
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= 16'h0000;
    end else if (rd) begin
      unique case (addr)
        srx_pkg::ADDR_CTRL: rdata_r <= {12'h000, ctrl_r};
        srx_pkg::ADDR_STAT: rdata_r <= {12'h000, stat_r};
        srx_pkg::ADDR_IEN: rdata_r <= {12'h000, ien_r};
        srx_pkg::ADDR_DATA: rdata_r <= {7'h00, data_r};
        srx_pkg::ADDR_DIV: rdata_r <= div_r;
        default: rdata_r <= 16'h0000;
      endcase
    end else begin
      rdata_r <= 16'h0000;
    end
  end
  assign rdata = rdata_r;
  // interrupt masked in standby
  assign irq = |(stat_r & ien_r) & ~ctrl_r[srx_pkg::CTRL_STANDBY];
endmodule

/* File: shared/srx_pkg.sv */
package srx_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [3:0] ADDR_CTRL = 4'h0; // control word
  localparam logic [3:0] ADDR_STAT = 4'h1; // sticky status
  localparam logic [3:0] ADDR_CLR = 4'h2; // write-one clear
  localparam logic [3:0] ADDR_IEN = 4'h3; // interrupt enable
  localparam logic [3:0] ADDR_DATA = 4'h4; // receive data
  localparam logic [3:0] ADDR_DIV = 4'h5; // tick divider
  // control fields
  localparam int CTRL_RXEN = 0;
  localparam int CTRL_NINE = 1;
  localparam int CTRL_STANDBY = 2;
  localparam int CTRL_WAKE = 3;
  // status fields
  localparam int ST_FULL = 0;
  localparam int ST_FE = 1;
  localparam int ST_NOISE = 2;
  localparam int ST_IDLE = 3;
  localparam int ST_W = 4;
  // tick layout
  localparam logic [3:0] TICK_S1 = 4'h8;
  localparam logic [3:0] TICK_S2 = 4'h9;
  localparam logic [3:0] TICK_S3 = 4'hA;
  localparam logic [3:0] TICK_LAST = 4'hF;
  localparam logic [2:0] EDGE_HIGHS = 3'h3;
  localparam logic [3:0] IDLE_BITS = 4'hA;
  localparam logic [15:0] DIV_RESET = 16'h0001;
  typedef enum logic [1:0] {
    SRX_HUNT = 2'b00,
    SRX_START = 2'b01,
    SRX_DATA = 2'b11,
    SRX_STOP = 2'b10
  } srx_state_t;
endpackage

/* File: shared/srx_tick_if.sv */
`timescale 1ns/1ps
interface srx_tick_if;
  logic [15:0] div;
  logic restart;
  logic tick;
  modport gen (input div, input restart, output tick);
  modport use_side (output div, output restart, input tick);
endinterface

/* File: verilog/srx_tick_gen.sv */
`timescale 1ns/1ps
module srx_tick_gen (
  input wire logic core_clk, // module clock
  input wire logic rst_b, // async reset, low
  srx_tick_if.gen tk // divider and tick
);
  logic [15:0] cnt_r;
  logic tick_r;
  // ****************************************************************
  // oversample tick divider
  // ****************************************************************
  // divide core clock into one tick pulse per divider period
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 16'h0000;
      tick_r <= 1'b0;
    end else if (tk.restart) begin
      cnt_r <= 16'h0000;
      tick_r <= 1'b0;
    end else if (cnt_r + 16'h0001 >= tk.div) begin
      cnt_r <= 16'h0000;
      tick_r <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
      tick_r <= 1'b0;
    end
  end
  assign tk.tick = tick_r;
endmodule

/* File: tb/srx_tx_model.sv */
`timescale 1ns/1ps
module srx_tx_model (
  input wire logic core_clk, // module clock
  output logic line // serial line out
);
  // ****************************************************************
  // idle line and frame sender, 16 clocks per bit
  // ****************************************************************
  initial begin
    line = 1'b1;
  end
  // one bit time; a one-clock inverted spike at clock 8 when g is set
  task automatic bit_out(input logic b, input logic g);
    @(posedge core_clk);
    line <= b;
    repeat (8) @(posedge core_clk);
    line <= b ^ g;
    @(posedge core_clk);
    line <= b;
    repeat (6) @(posedge core_clk);
  endtask
  // start, data lsb first, stop; msb of data may mark an address
  // gl picks the frame bit that carries a noise spike, -1 for none
  task automatic send(input logic [8:0] d, input logic nine,
                      input logic stop_v, input int gl = -1);
    logic [10:0] bits;
    int n;
    n = nine ? 11 : 10;
    bits = nine ? {stop_v, d, 1'b0} : {1'b1, stop_v, d[7:0], 1'b0};
    for (int i = 0; i < n; i++) begin
      bit_out(bits[i], i == gl);
    end
    @(posedge core_clk);
    line <= 1'b1;
  endtask
endmodule

/* File: tb/srx_receiver_assertions.sv */
`timescale 1ns/1ps
module srx_receiver_assertions (
  input wire logic core_clk, // module clock
  input wire logic rst_b, // async reset, low
  input wire logic rxd, // serial line in
  input wire logic [3:0] addr, // register address
  input wire logic [15:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  input wire logic [15:0] rdata, // read data
  input wire logic irq // level interrupt
);
  // ****************************************************************
  // bus and interrupt relations
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == 16'h0000)
    else $error("read data not zero outside answer cycle");
  AST_RESET_QUIET: assert property (!$past(rst_b) |-> rdata == 16'h0000
    && !irq) else $error("outputs not quiet after reset");
  AST_UNMAPPED: assert property (rd && addr > 4'h5 |=> rdata == 16'h0000)
    else $error("unmapped read not zero");
  AST_STAT_W: assert property (rd && addr == srx_pkg::ADDR_STAT
    |=> rdata[15:4] == 12'h000) else $error("status upper bits set");
  AST_DATA_W: assert property (rd && addr == srx_pkg::ADDR_DATA
    |=> rdata[15:9] == 7'h00) else $error("data upper bits set");
  AST_CTRL_W: assert property (rd && addr == srx_pkg::ADDR_CTRL
    |=> rdata[15:4] == 12'h000) else $error("control upper bits set");
  AST_STANDBY_IRQ: assert property (wr && addr == srx_pkg::ADDR_CTRL
    && wdata[srx_pkg::CTRL_STANDBY] |=> !irq [*8])
    else $error("interrupt in standby");
  AST_IEN_OFF: assert property (wr && addr == srx_pkg::ADDR_IEN
    && wdata == 16'h0000 |=> !irq) else $error("interrupt while disabled");
  AST_COV_IRQ: cover property ($rose(irq));
  AST_COV_DATA_RD: cover property (rd && addr == srx_pkg::ADDR_DATA);
  AST_COV_STANDBY: cover property (wr && addr == srx_pkg::ADDR_CTRL
    && wdata[srx_pkg::CTRL_STANDBY]);
endmodule
bind srx_receiver srx_receiver_assertions i_chk (.core_clk(core_clk),
  .rst_b(rst_b), .rxd(rxd), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .irq(irq));

/* File: tb/srx_receiver_test.sv */
`timescale 1ns/1ps
module srx_receiver_test;
  // ****************************************************************
  // clock, reset, design and far side
  // ****************************************************************
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic rxd;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic irq;
  logic [15:0] rv;
  int err_count = 0;
  int n_checks = 0;
  int c;
  always #2.5 core_clk = ~core_clk;
  srx_receiver i_dut (.core_clk(core_clk), .rst_b(rst_b), .rxd(rxd),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
  srx_tx_model i_tx (.core_clk(core_clk), .line(rxd));
  // ****************************************************************
  // bus tasks and compares
  // ****************************************************************
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    rv = rdata;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_t(input int got, input int lo);
    n_checks++;
    if (got < lo || got > lo + 6) begin
      err_count++;
      $display("[FAIL] %0t frame took %0d ticks", $time, got);
    end
  endtask
  // frame with tick count from start edge to interrupt
  task automatic timed(input logic [8:0] d, input logic nine);
    fork
      i_tx.send(d, nine, 1'b1);
      begin
        c = 0;
        while (irq !== 1'b1 && c < 400) begin
          @(posedge core_clk);
          #1;
          c++;
        end
      end
    join
  endtask
  task automatic stat(input logic [15:0] exp);
    rd_reg(srx_pkg::ADDR_STAT);
    chk(rv & 16'h0003, exp);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // watchdog well beyond the frame sequence
  initial begin
    #200000;
    err_count++;
    wrap_up();
  end
  // ****************************************************************
  // test sequence
  // ****************************************************************
  initial begin
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    rd_reg(srx_pkg::ADDR_CTRL); chk(rv, 16'h0000);
    rd_reg(srx_pkg::ADDR_DIV); chk(rv, srx_pkg::DIV_RESET);
    wr_reg(srx_pkg::ADDR_DIV, 16'h0003);
    rd_reg(srx_pkg::ADDR_DIV); chk(rv, 16'h0003);
    wr_reg(srx_pkg::ADDR_DIV, srx_pkg::DIV_RESET);
    rd_reg(4'hF); chk(rv, 16'h0000);
    wr_reg(4'hF, 16'hFFFF);
    wr_reg(srx_pkg::ADDR_STAT, 16'hFFFF); stat(16'h0000);
    wr_reg(srx_pkg::ADDR_CTRL, 16'h0001);
    wr_reg(srx_pkg::ADDR_IEN, 16'h0003);
    timed(9'h0A5, 1'b0); chk_t(c, 154);
    stat(16'h0001);
    rd_reg(srx_pkg::ADDR_DATA); chk(rv, 16'h00A5);
    wr_reg(srx_pkg::ADDR_CLR, 16'hFFFF); stat(16'h0000);
    chk({15'h0, irq}, 16'h0000);
    wr_reg(srx_pkg::ADDR_CTRL, 16'h0003);
    timed(9'h1C3, 1'b1); chk_t(c, 170);
    rd_reg(srx_pkg::ADDR_DATA); chk(rv, 16'h01C3);
    chk({15'h0, irq}, 16'h0001);
    wr_reg(srx_pkg::ADDR_IEN, 16'h0000);
    rd_reg(srx_pkg::ADDR_IEN); chk(rv, 16'h0000);
    chk({15'h0, irq}, 16'h0000);
    wr_reg(srx_pkg::ADDR_IEN, 16'h0003);
    wr_reg(srx_pkg::ADDR_CTRL, 16'h0001);
    wr_reg(srx_pkg::ADDR_CLR, 16'hFFFF);
    i_tx.send(9'h05A, 1'b0, 1'b1, 1);
    rd_reg(srx_pkg::ADDR_STAT); chk(rv & 16'h0007, 16'h0005);
    rd_reg(srx_pkg::ADDR_DATA); chk(rv, 16'h005A);
    wr_reg(srx_pkg::ADDR_CLR, 16'hFFFF);
    i_tx.send(9'h0A5, 1'b0, 1'b1, 0);
    rd_reg(srx_pkg::ADDR_STAT); chk(rv & 16'h0007, 16'h0001);
    rd_reg(srx_pkg::ADDR_DATA); chk(rv, 16'h00A5);
    wr_reg(srx_pkg::ADDR_CLR, 16'hFFFF);
    i_tx.send(9'h055, 1'b0, 1'b0); stat(16'h0003);
    wr_reg(srx_pkg::ADDR_CLR, 16'hFFFF);
    i_tx.send(9'h000, 1'b0, 1'b0); stat(16'h0003);
    chk({15'h0, irq}, 16'h0001);
    wr_reg(srx_pkg::ADDR_CTRL, 16'h000D);
    rd_reg(srx_pkg::ADDR_CTRL); chk({15'h0, irq}, 16'h0000);
    wr_reg(srx_pkg::ADDR_CLR, 16'hFFFF);
    i_tx.send(9'h033, 1'b0, 1'b1); stat(16'h0000);
    chk({15'h0, irq}, 16'h0000);
    rd_reg(srx_pkg::ADDR_DATA); chk(rv, 16'h0033);
    rd_reg(srx_pkg::ADDR_CTRL); chk(rv & 16'h0004, 16'h0004);
    i_tx.send(9'h0B3, 1'b0, 1'b1);
    rd_reg(srx_pkg::ADDR_CTRL); chk(rv & 16'h0004, 16'h0000);
    wr_reg(srx_pkg::ADDR_CTRL, 16'h0005);
    rd_reg(srx_pkg::ADDR_CTRL); chk(rv & 16'h0004, 16'h0004);
    repeat (240) @(posedge core_clk);
    rd_reg(srx_pkg::ADDR_CTRL); chk(rv & 16'h0004, 16'h0000);
    wrap_up();
  end
endmodule
